// >>> logic/ovcb_regs.svh
// Register offsets, field positions, reset values and timing counts of the output volume bank
`ifndef OVCB_REGS_SVH
`define OVCB_REGS_SVH

// ----------------------------------------
// Register offsets
// ----------------------------------------
`define OVCB_ADDR_W 8
`define OVCB_LINE_LEFT_LEVEL 8'h3b
`define OVCB_LINE_RIGHT_LEVEL 8'h3c
`define OVCB_DIFF_LEFT_LEVEL 8'h3e
`define OVCB_DIFF_RIGHT_LEVEL 8'h3f
`define OVCB_ZERO_WAIT_CTRL 8'h40

// ----------------------------------------
// Field positions
// ----------------------------------------
`define OVCB_DATA_W 9
`define OVCB_SILENCE_BIT 8
`define OVCB_APPLY_BIT 7
`define OVCB_ZERO_GATE_BIT 6
`define OVCB_GAIN_HI 5
`define OVCB_GAIN_LO 0
`define OVCB_TIMEOUT_EN_BIT 0

// ----------------------------------------
// Reset values
// ----------------------------------------
`define OVCB_GAIN_RESET 6'h39
`define OVCB_LINE_SILENCE_RESET 1'h0
`define OVCB_DIFF_SILENCE_RESET 1'h1

// ----------------------------------------
// Zero-wait timeout
// ----------------------------------------
`define OVCB_CLK_MHZ 25
`define OVCB_TIMEOUT_US 100
`define OVCB_TIMEOUT_CYC (`OVCB_TIMEOUT_US * `OVCB_CLK_MHZ)
`define OVCB_TIMER_W 12

`endif

// >>> logic/ovcb_pkg.sv
// Types shared by the output volume bank
package ovcb_pkg;

	typedef enum logic [1:0] {
		OVCB_IDLE,
		OVCB_WAIT
	} ovcb_chan_state_t;

	typedef struct packed {
		logic silence;
		logic zero_gate;
		logic [5:0] stored_gain;
		logic [5:0] active_gain;
		ovcb_chan_state_t st;
		logic [11:0] timer;
	} ovcb_chan_t;

	typedef struct packed {
		ovcb_chan_t line_l;
		ovcb_chan_t line_r;
		ovcb_chan_t diff_l;
		ovcb_chan_t diff_r;
		logic timeout_en;
		logic [8:0] rdata;
	} ovcb_state_t;

endpackage

// >>> logic/ovcb_bank.sv
// Output volume bank: line and differential mute, zero-cross and gain registers
//
// Function
// - Line silence bit 8 resets to 0
// - Differential silence bit 8 resets to 1
// - Line bit 7 applies both line gains
// - Differential bit 7 applies both differential gains
// - Line zero-gate enable bit 6, reset 0
// - Differential zero-gate enable bit 6, reset 0
// - Gain code 0 is -57dB, 1dB steps
// - All gains reset to unity code
// - Stored gain waits for apply trigger
// - Zero-gated change waits for zero crossing
// - Enabled timeout forces deferred change through
//
// The implementer's own choice: strobed register access.
`timescale 1ns/1ps
`include "ovcb_regs.svh"

module ovcb_bank (
	input wire logic clk,
	input wire logic srst,
	input wire logic ce,
	input wire logic [`OVCB_ADDR_W-1:0] addr,
	input wire logic [`OVCB_DATA_W-1:0] wdata,
	input wire logic wr,
	input wire logic rd,
	output logic [`OVCB_DATA_W-1:0] rdata,
	input wire logic [3:0] zero_cross,
	output logic line_left_silence,
	output logic line_right_silence,
	output logic diff_left_silence,
	output logic diff_right_silence,
	output logic [5:0] line_left_gain,
	output logic [5:0] line_right_gain,
	output logic [5:0] diff_left_gain,
	output logic [5:0] diff_right_gain
);

	ovcb_pkg::ovcb_state_t s;
	ovcb_pkg::ovcb_state_t next_s;

	localparam logic [11:0] TIMEOUT_LAST = 12'(`OVCB_TIMEOUT_CYC - 1);

	// ----------------------------------------
	// Per-channel helpers
	// ----------------------------------------
	function automatic ovcb_pkg::ovcb_chan_t chan_write(ovcb_pkg::ovcb_chan_t c,
			logic [`OVCB_DATA_W-1:0] d);
		ovcb_pkg::ovcb_chan_t n;
		n = c;
		n.silence = d[`OVCB_SILENCE_BIT];
		n.zero_gate = d[`OVCB_ZERO_GATE_BIT];
		n.stored_gain = d[`OVCB_GAIN_HI:`OVCB_GAIN_LO];
		return n;
	endfunction

	// Apply request, zero crossing and timeout move stored gain to active gain
	function automatic ovcb_pkg::ovcb_chan_t chan_step(ovcb_pkg::ovcb_chan_t c,
			logic apply, logic zc, logic to_en);
		ovcb_pkg::ovcb_chan_t n;
		n = c;
		case (c.st)
			ovcb_pkg::OVCB_IDLE: begin
				if (apply) begin
					if (c.zero_gate) begin
						n.st = ovcb_pkg::OVCB_WAIT;
						n.timer = '0;
					end else begin
						n.active_gain = c.stored_gain;
					end
				end
			end
			ovcb_pkg::OVCB_WAIT: begin
				// Gain taken at the moment of release, so a later store still counts
				if (zc || !c.zero_gate) begin
					n.active_gain = c.stored_gain;
					n.st = ovcb_pkg::OVCB_IDLE;
				end else if (to_en && c.timer == TIMEOUT_LAST) begin
					n.active_gain = c.stored_gain;
					n.st = ovcb_pkg::OVCB_IDLE;
				end else if (to_en) begin
					n.timer = c.timer + 12'h001;
				end
			end
			default: begin
				n.st = ovcb_pkg::OVCB_IDLE;
			end
		endcase
		return n;
	endfunction

	function automatic logic [`OVCB_DATA_W-1:0] chan_read(ovcb_pkg::ovcb_chan_t c);
		// Apply bit holds no state and reads as zero
		return {c.silence, 1'b0, c.zero_gate, c.stored_gain};
	endfunction

	// ----------------------------------------
	// Next state
	// ----------------------------------------
	logic line_apply;
	logic diff_apply;
	logic wr_line_l;
	logic wr_line_r;
	logic wr_diff_l;
	logic wr_diff_r;

	always_comb begin
		next_s = s;
		wr_line_l = wr && addr == `OVCB_LINE_LEFT_LEVEL;
		wr_line_r = wr && addr == `OVCB_LINE_RIGHT_LEVEL;
		wr_diff_l = wr && addr == `OVCB_DIFF_LEFT_LEVEL;
		wr_diff_r = wr && addr == `OVCB_DIFF_RIGHT_LEVEL;
		line_apply = (wr_line_l || wr_line_r) && wdata[`OVCB_APPLY_BIT];
		diff_apply = (wr_diff_l || wr_diff_r) && wdata[`OVCB_APPLY_BIT];
		if (wr_line_l) begin
			next_s.line_l = chan_write(s.line_l, wdata);
		end
		if (wr_line_r) begin
			next_s.line_r = chan_write(s.line_r, wdata);
		end
		if (wr_diff_l) begin
			next_s.diff_l = chan_write(s.diff_l, wdata);
		end
		if (wr_diff_r) begin
			next_s.diff_r = chan_write(s.diff_r, wdata);
		end
		if (wr && addr == `OVCB_ZERO_WAIT_CTRL) begin
			next_s.timeout_en = wdata[`OVCB_TIMEOUT_EN_BIT];
		end
		// Stored value from this same write is the one applied
		next_s.line_l = chan_step(next_s.line_l, line_apply, zero_cross[0], s.timeout_en);
		next_s.line_r = chan_step(next_s.line_r, line_apply, zero_cross[1], s.timeout_en);
		next_s.diff_l = chan_step(next_s.diff_l, diff_apply, zero_cross[2], s.timeout_en);
		next_s.diff_r = chan_step(next_s.diff_r, diff_apply, zero_cross[3], s.timeout_en);
		next_s.rdata = '0;
		if (rd) begin
			case (addr)
				`OVCB_LINE_LEFT_LEVEL: next_s.rdata = chan_read(s.line_l);
				`OVCB_LINE_RIGHT_LEVEL: next_s.rdata = chan_read(s.line_r);
				`OVCB_DIFF_LEFT_LEVEL: next_s.rdata = chan_read(s.diff_l);
				`OVCB_DIFF_RIGHT_LEVEL: next_s.rdata = chan_read(s.diff_r);
				`OVCB_ZERO_WAIT_CTRL: next_s.rdata = {8'h00, s.timeout_en};
				default: next_s.rdata = '0;
			endcase
		end
	end

	// ----------------------------------------
	// State register
	// ----------------------------------------
	always_ff @(posedge clk) begin
		if (srst) begin
			s <= '0;
			s.line_l.silence <= `OVCB_LINE_SILENCE_RESET;
			s.line_r.silence <= `OVCB_LINE_SILENCE_RESET;
			s.diff_l.silence <= `OVCB_DIFF_SILENCE_RESET;
			s.diff_r.silence <= `OVCB_DIFF_SILENCE_RESET;
			s.line_l.stored_gain <= `OVCB_GAIN_RESET;
			s.line_r.stored_gain <= `OVCB_GAIN_RESET;
			s.diff_l.stored_gain <= `OVCB_GAIN_RESET;
			s.diff_r.stored_gain <= `OVCB_GAIN_RESET;
			s.line_l.active_gain <= `OVCB_GAIN_RESET;
			s.line_r.active_gain <= `OVCB_GAIN_RESET;
			s.diff_l.active_gain <= `OVCB_GAIN_RESET;
			s.diff_r.active_gain <= `OVCB_GAIN_RESET;
		end else if (ce) begin
			s <= next_s;
		end
	end

	// Gain code passes unchanged; analogue stage maps code 0 to -57dB
	assign rdata = s.rdata;
	assign line_left_silence = s.line_l.silence;
	assign line_right_silence = s.line_r.silence;
	assign diff_left_silence = s.diff_l.silence;
	assign diff_right_silence = s.diff_r.silence;
	assign line_left_gain = s.line_l.active_gain;
	assign line_right_gain = s.line_r.active_gain;
	assign diff_left_gain = s.diff_l.active_gain;
	assign diff_right_gain = s.diff_r.active_gain;

	// ----------------------------------------
	// Checks
	// ----------------------------------------
	default clocking cb @(posedge clk); endclocking
	default disable iff (srst);

	// ----------------------------------------
	// Reset values
	// ----------------------------------------
	a_line_silence_reset: assert property (
		$fell(srst) |-> !line_left_silence && !line_right_silence
	) else $error("line silence not 0 after reset");

	a_diff_silence_reset: assert property (
		$fell(srst) |-> diff_left_silence && diff_right_silence
	) else $error("diff silence not 1 after reset");

	a_gain_unity_reset: assert property (
		$fell(srst) |-> line_left_gain == `OVCB_GAIN_RESET && diff_right_gain == `OVCB_GAIN_RESET
	) else $error("gain not unity after reset");

	a_gain_unity_other: assert property (
		$fell(srst) |-> line_right_gain == `OVCB_GAIN_RESET && diff_left_gain == `OVCB_GAIN_RESET
	) else $error("other gains not unity after reset");

	// ----------------------------------------
	// Pair apply
	// ----------------------------------------
	a_line_pair_apply: assert property (
		ce && wr_line_r && wdata[`OVCB_APPLY_BIT] && !s.line_l.zero_gate
		&& s.line_l.st == ovcb_pkg::OVCB_IDLE
		|=> line_left_gain == $past(next_s.line_l.stored_gain)
	) else $error("line left not applied");

	a_line_right_apply: assert property (
		ce && wr_line_l && wdata[`OVCB_APPLY_BIT] && !s.line_r.zero_gate
		&& s.line_r.st == ovcb_pkg::OVCB_IDLE
		|=> line_right_gain == $past(s.line_r.stored_gain)
	) else $error("line right not applied");

	a_line_self_apply: assert property (
		ce && wr_line_l && wdata[`OVCB_APPLY_BIT] && !wdata[`OVCB_ZERO_GATE_BIT]
		&& s.line_l.st == ovcb_pkg::OVCB_IDLE
		|=> line_left_gain == $past(wdata[`OVCB_GAIN_HI:`OVCB_GAIN_LO])
	) else $error("line left own value not applied");

	a_diff_pair_apply: assert property (
		ce && wr_diff_l && wdata[`OVCB_APPLY_BIT] && !s.diff_r.zero_gate
		&& s.diff_r.st == ovcb_pkg::OVCB_IDLE
		|=> diff_right_gain == $past(next_s.diff_r.stored_gain)
	) else $error("diff right not applied");

	a_diff_left_apply: assert property (
		ce && wr_diff_r && wdata[`OVCB_APPLY_BIT] && !s.diff_l.zero_gate
		&& s.diff_l.st == ovcb_pkg::OVCB_IDLE
		|=> diff_left_gain == $past(s.diff_l.stored_gain)
	) else $error("diff left not applied");

	a_diff_self_apply: assert property (
		ce && wr_diff_r && wdata[`OVCB_APPLY_BIT] && !wdata[`OVCB_ZERO_GATE_BIT]
		&& s.diff_r.st == ovcb_pkg::OVCB_IDLE
		|=> diff_right_gain == $past(wdata[`OVCB_GAIN_HI:`OVCB_GAIN_LO])
	) else $error("diff right own value not applied");

	a_gain_needs_apply: assert property (
		ce && !line_apply && s.line_l.st == ovcb_pkg::OVCB_IDLE |=> $stable(line_left_gain)
	) else $error("line gain changed without apply");

	a_diff_needs_apply: assert property (
		ce && !diff_apply && s.diff_r.st == ovcb_pkg::OVCB_IDLE |=> $stable(diff_right_gain)
	) else $error("diff gain changed without apply");

	// ----------------------------------------
	// Mute and zero-gate storage
	// ----------------------------------------
	a_line_silence_write: assert property (
		ce && wr_line_l |=> line_left_silence == $past(wdata[`OVCB_SILENCE_BIT])
	) else $error("line silence not taken");

	a_diff_silence_write: assert property (
		ce && wr_diff_l |=> diff_left_silence == $past(wdata[`OVCB_SILENCE_BIT])
	) else $error("diff silence not taken");

	a_line_gate_store: assert property (
		ce && wr_line_r |=> s.line_r.zero_gate == $past(wdata[`OVCB_ZERO_GATE_BIT])
	) else $error("line zero gate not taken");

	a_diff_gate_store: assert property (
		ce && wr_diff_l |=> s.diff_l.zero_gate == $past(wdata[`OVCB_ZERO_GATE_BIT])
	) else $error("diff zero gate not taken");

	// ----------------------------------------
	// Zero-cross wait and timeout
	// ----------------------------------------
	// A write that clears the gate releases at once, so it is left out here
	a_line_zero_hold: assert property (
		ce && s.line_l.st == ovcb_pkg::OVCB_WAIT && s.line_l.zero_gate
		&& !zero_cross[0] && !s.timeout_en && !wr_line_l |=> $stable(line_left_gain)
	) else $error("line gain moved without crossing");

	a_diff_zero_hold: assert property (
		ce && s.diff_r.st == ovcb_pkg::OVCB_WAIT && s.diff_r.zero_gate
		&& !zero_cross[3] && !s.timeout_en && !wr_diff_r |=> $stable(diff_right_gain)
	) else $error("diff gain moved without crossing");

	a_diff_left_hold: assert property (
		ce && s.diff_l.st == ovcb_pkg::OVCB_WAIT && s.diff_l.zero_gate
		&& !zero_cross[2] && !s.timeout_en && !wr_diff_l |=> $stable(diff_left_gain)
	) else $error("diff left moved without crossing");

	a_line_gate_wait: assert property (
		ce && line_apply && next_s.line_l.zero_gate && s.line_l.st == ovcb_pkg::OVCB_IDLE
		|=> s.line_l.st == ovcb_pkg::OVCB_WAIT
	) else $error("gated apply did not wait");

	a_zero_release: assert property (
		ce && s.line_r.st == ovcb_pkg::OVCB_WAIT && zero_cross[1]
		|=> line_right_gain == $past(s.line_r.stored_gain) || $past(wr_line_r)
	) else $error("crossing did not release gain");

	a_diff_zero_release: assert property (
		ce && s.diff_l.st == ovcb_pkg::OVCB_WAIT && zero_cross[2]
		|=> s.diff_l.st == ovcb_pkg::OVCB_IDLE
	) else $error("diff crossing did not end wait");

	a_gate_clear_release: assert property (
		ce && s.line_l.st == ovcb_pkg::OVCB_WAIT && !next_s.line_l.zero_gate
		|=> s.line_l.st == ovcb_pkg::OVCB_IDLE
	) else $error("cleared gate did not release");

	a_timeout_release: assert property (
		ce && s.diff_l.st == ovcb_pkg::OVCB_WAIT && s.timeout_en
		&& s.diff_l.timer == TIMEOUT_LAST |=> s.diff_l.st == ovcb_pkg::OVCB_IDLE
	) else $error("timeout did not release");

	a_timer_frozen: assert property (
		ce && s.line_l.st == ovcb_pkg::OVCB_WAIT && !s.timeout_en |=> $stable(s.line_l.timer)
	) else $error("timer ran while timeout off");

	a_timer_count: assert property (
		ce && s.line_l.st == ovcb_pkg::OVCB_WAIT && s.timeout_en && s.line_l.zero_gate
		&& !zero_cross[0] && !wr_line_l && s.line_l.timer != TIMEOUT_LAST
		|=> s.line_l.timer == $past(s.line_l.timer) + 12'h001
	) else $error("timer did not count");

	a_ctrl_write: assert property (
		ce && wr && addr == `OVCB_ZERO_WAIT_CTRL
		|=> s.timeout_en == $past(wdata[`OVCB_TIMEOUT_EN_BIT])
	) else $error("timeout enable not taken");

	// ----------------------------------------
	// Clock enable
	// ----------------------------------------
	a_ce_freeze_gain: assert property (
		!ce |=> $stable(line_left_gain) && $stable(line_right_gain)
		&& $stable(diff_left_gain) && $stable(diff_right_gain)
	) else $error("gain moved while clock enable low");

	a_ce_freeze_silence: assert property (
		!ce |=> $stable(line_left_silence) && $stable(line_right_silence)
		&& $stable(diff_left_silence) && $stable(diff_right_silence)
	) else $error("silence moved while clock enable low");

	a_ce_freeze_rdata: assert property (
		!ce |=> $stable(rdata)
	) else $error("read data moved while clock enable low");

	// ----------------------------------------
	// Read path
	// ----------------------------------------
	a_apply_reads_zero: assert property (
		rd && ce |=> !rdata[`OVCB_APPLY_BIT]
	) else $error("apply bit read as one");

	a_rd_stored_gain: assert property (
		rd && ce && addr == `OVCB_LINE_LEFT_LEVEL
		|=> rdata[`OVCB_GAIN_HI:`OVCB_GAIN_LO] == $past(s.line_l.stored_gain)
	) else $error("stored gain not read back");

	a_rd_diff_silence: assert property (
		rd && ce && addr == `OVCB_DIFF_RIGHT_LEVEL
		|=> rdata[`OVCB_SILENCE_BIT] == $past(s.diff_r.silence)
	) else $error("diff silence not read back");

	a_rd_unmapped: assert property (
		rd && ce && addr == 8'h00 |=> rdata == '0
	) else $error("unmapped read not zero");

	a_rdata_idle: assert property (
		ce && !rd |=> rdata == '0
	) else $error("read data not zero without read");

	// ----------------------------------------
	// Cover points
	// ----------------------------------------
	c_line_apply: cover property (ce && line_apply);
	c_zero_wait: cover property (
		s.line_l.st == ovcb_pkg::OVCB_WAIT ##1 s.line_l.st == ovcb_pkg::OVCB_IDLE);
	c_diff_unsilence: cover property (ce && wr_diff_l && !wdata[`OVCB_SILENCE_BIT]);
	c_timeout_fire: cover property (
		ce && s.line_l.st == ovcb_pkg::OVCB_WAIT && s.timeout_en
		&& s.line_l.timer == TIMEOUT_LAST);
	c_ce_held_write: cover property (!ce && wr);

endmodule

// >>> tb/ovcb_bank_tb_top.sv
// Self-checking bench for the output volume bank
`timescale 1ns/1ps
`include "ovcb_regs.svh"

module ovcb_bank_tb_top;
	logic clk, srst, ce, wr, rd;
	logic [7:0] addr;
	logic [8:0] wdata, rdata;
	logic [3:0] zero_cross;
	logic ll_sil, lr_sil, dl_sil, dr_sil;
	logic [5:0] ll_gain, lr_gain, dl_gain, dr_gain;
	int errors, check_count, n;

	ovcb_bank u_dut (.clk(clk), .srst(srst), .ce(ce), .addr(addr), .wdata(wdata), .wr(wr),
		.rd(rd), .rdata(rdata), .zero_cross(zero_cross), .line_left_silence(ll_sil),
		.line_right_silence(lr_sil), .diff_left_silence(dl_sil), .diff_right_silence(dr_sil),
		.line_left_gain(ll_gain), .line_right_gain(lr_gain), .diff_left_gain(dl_gain),
		.diff_right_gain(dr_gain));

	initial begin
		clk = 1'b0;
		forever #20 clk = ~clk;
	end

	// ----------------------------------------
	// Access and compare tasks
	// ----------------------------------------
	task automatic chk(input string name, input logic [11:0] exp, input logic [11:0] got);
		check_count++;
		if (got !== exp) begin
			errors++;
			$display("Error %s expected %h seen %h", name, exp, got);
		end
	endtask

	// One idle cycle after each strobe, so no strobe is assigned twice in one step
	task automatic wr_reg(input logic [7:0] a, input logic [8:0] d);
		@(posedge clk);
		wr <= 1'b1;
		addr <= a;
		wdata <= d;
		@(posedge clk);
		wr <= 1'b0;
		#1;
	endtask

	task automatic rd_chk(input string name, input logic [7:0] a, input logic [8:0] exp);
		@(posedge clk);
		rd <= 1'b1;
		addr <= a;
		@(posedge clk);
		rd <= 1'b0;
		#1;
		chk(name, {3'h0, exp}, {3'h0, rdata});
	endtask

	task automatic cyc(input int k);
		repeat (k) @(posedge clk);
		#1;
	endtask

	task automatic print_verdict();
		$display("Comparisons %0d, mismatches %0d", check_count, errors);
		if (errors == 0 && check_count > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask

	initial begin
		srst = 1'b1;
		ce = 1'b1;
		wr = 1'b0;
		rd = 1'b0;
		addr = 8'h00;
		wdata = 9'h000;
		zero_cross = 4'h0;
		errors = 0;
		check_count = 0;
		repeat (4) @(posedge clk);
		srst <= 1'b0;
		#1;
		chk("silences", 12'h003, {8'h0, ll_sil, lr_sil, dl_sil, dr_sil});
		chk("line_gains", 12'he79, {lr_gain, ll_gain});
		chk("diff_gains", 12'he79, {dr_gain, dl_gain});
		rd_chk("line_left_rd", 8'h3b, 9'h039);
		rd_chk("line_right_rd", 8'h3c, 9'h039);
		rd_chk("diff_left_rd", 8'h3e, 9'h139);
		rd_chk("diff_right_rd", 8'h3f, 9'h139);
		rd_chk("unmapped_rd", 8'h3d, 9'h000);
		$display("Test reset done");

		// Staged values must not reach the outputs before the trigger
		wr_reg(8'h3b, 9'h000);
		wr_reg(8'h3c, 9'h03f);
		chk("line_staged", 12'he79, {lr_gain, ll_gain});
		wr_reg(8'h3c, 9'h0bf);
		chk("line_applied", 12'hfc0, {lr_gain, ll_gain});
		chk("diff_untouched", 12'he79, {dr_gain, dl_gain});
		rd_chk("apply_reads_zero", 8'h3c, 9'h03f);
		wr_reg(8'h3f, 9'h105);
		wr_reg(8'h3e, 9'h0b9);
		chk("diff_applied", 12'h179, {dr_gain, dl_gain});
		chk("diff_unmute", 12'h001, {8'h0, ll_sil, lr_sil, dl_sil, dr_sil});
		wr_reg(8'h3b, 9'h100);
		chk("line_mute", 12'h009, {8'h0, ll_sil, lr_sil, dl_sil, dr_sil});
		$display("Test apply done");

		// Gated channel holds its old gain until a crossing arrives
		wr_reg(8'h3e, 9'h0c0);
		cyc(20);
		chk("gated_hold", 12'h179, {dr_gain, dl_gain});
		rd_chk("gate_rd", 8'h3e, 9'h040);
		@(posedge clk);
		zero_cross <= 4'h4;
		@(posedge clk);
		zero_cross <= 4'h0;
		cyc(2);
		chk("gated_release", 12'h140, {dr_gain, dl_gain});
		$display("Test zero gate done");

		// No crossing at all: only the timeout can release the change
		wr_reg(8'h40, 9'h001);
		wr_reg(8'h3b, 9'h1e1);
		rd_chk("line_gate_rd", 8'h3b, 9'h161);
		n = 0;
		while (ll_gain !== 6'h21 && n < 3000) begin
			cyc(1);
			n++;
		end
		chk("timeout_window", 12'h001, {11'h0, n >= 2480 && n <= 2510});
		chk("timeout_gains", 12'hfe1, {lr_gain, ll_gain});
		$display("Test timeout done");

		// Clock enable low: a write must leave everything as it was
		@(posedge clk);
		ce <= 1'b0;
		wr_reg(8'h3c, 9'h1a0);
		chk("ce_gains", 12'hfe1, {lr_gain, ll_gain});
		chk("ce_silences", 12'h009, {8'h0, ll_sil, lr_sil, dl_sil, dr_sil});
		@(posedge clk);
		ce <= 1'b1;
		rd_chk("ce_rd", 8'h3c, 9'h03f);
		// Unmapped write is ignored
		wr_reg(8'h3d, 9'h1ff);
		chk("unmapped_gains", 12'hfe1, {lr_gain, ll_gain});
		chk("unmapped_sil", 12'h009, {8'h0, ll_sil, lr_sil, dl_sil, dr_sil});
		// Second reset in mid-run restores every default
		@(posedge clk);
		srst <= 1'b1;
		@(posedge clk);
		srst <= 1'b0;
		#1;
		chk("rst2_silences", 12'h003, {8'h0, ll_sil, lr_sil, dl_sil, dr_sil});
		chk("rst2_line_gains", 12'he79, {lr_gain, ll_gain});
		chk("rst2_diff_gains", 12'he79, {dr_gain, dl_gain});
		rd_chk("rst2_line_left_rd", 8'h3b, 9'h039);
		$display("Test enable and reset done");
		print_verdict();
	end
endmodule
